// ===== fdc_pkg.sv
/*
 * fdc_pkg: constants, types and register map for the flag keeper and
 * opcode decoder of the 8-bit core.
 * assumes one 125 MHz clock, one core clock per instruction cycle.
 */
package fdc_pkg;

    localparam int NUM_BASIC_OPS = 62;

    // register byte offsets
    localparam logic [4:0] REG_OPCODE = 5'h00;
    localparam logic [4:0] REG_ACC    = 5'h04;
    localparam logic [4:0] REG_IDX    = 5'h08;
    localparam logic [4:0] REG_MEM    = 5'h0c;
    localparam logic [4:0] REG_FLAGS  = 5'h10;
    localparam logic [4:0] REG_STAT   = 5'h14;
    localparam logic [4:0] REG_RESULT = 5'h18;
    localparam logic [4:0] REG_IRQ    = 5'h1c;

    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [4:0] RST_FLAGS = 5'h08;

    localparam logic [7:0] OPC_UPROD = 8'h42;
    localparam logic [7:0] OPC_BSR   = 8'had;
    localparam logic [3:0] UPROD_CYC = 4'hb;
    localparam logic [3:0] BR_CYC    = 4'h3;
    localparam logic [3:0] BSR_CYC   = 4'h6;
    localparam logic [3:0] BIT_CYC   = 4'h5;

    // register/memory modes a..f: imm, dir, ext, ix16, ix8, ix
    localparam logic [1:0] RM_LEN [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
    localparam logic [3:0] RM_CYC [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h3};
    // read/modify/write modes 3..7: dir, inh a, inh x, ix8, ix
    localparam logic [1:0] RMW_LEN [5] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h1};
    localparam logic [3:0] RMW_CYC [5] = '{4'h5, 4'h3, 4'h3, 4'h6, 4'h5};

    typedef enum logic [2:0] {
        CLS_NONE, CLS_REGMEM, CLS_RMW, CLS_BRANCH, CLS_BITMAN, CLS_CONTROL
    } fdc_cls_e;

    typedef enum logic [3:0] {
        MD_INH, MD_INH_A, MD_INH_X, MD_IMM, MD_DIR, MD_EXT,
        MD_IX, MD_IX8, MD_IX16, MD_REL
    } fdc_mode_e;

    typedef enum logic {ST_IDLE, ST_EXEC} fdc_fsm_e;

    // flags_register layout, bit 4 down to bit 0
    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } fdc_flags_s;

    typedef struct packed {
        logic      valid;
        fdc_cls_e  cls;
        fdc_mode_e mode;
        logic [1:0] len;
        logic [3:0] cyc;
    } fdc_dec_s;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] idx;
        logic [7:0] res;
        fdc_flags_s flg;
        logic       wb;
        logic       taken;
    } fdc_exe_s;

    // status register, low bits upward: cyc, len, mode, cls, valid, taken, wb, busy
    typedef struct packed {
        logic       busy;
        logic       wb;
        logic       taken;
        fdc_dec_s   dec;
    } fdc_stat_s;

endpackage : fdc_pkg

// ===== fdc_core.sv
/*
 * fdc_core: condition flags, opcode decode and one-shot execution of a
 * single instruction against a memory operand byte held in a register.
 * assumes an avalon-mm master on the same clock; memory traffic itself is
 * done by the surrounding core, which loads the operand before issue. */
`timescale 1ns/1ps
module fdc_core
    import fdc_pkg::*;
#(
    parameter int ADDR_W = 5
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              irq_req_i,
    input  wire logic              irq_pin_i,
    output logic                   irq_take_o
);

    typedef struct packed {
        fdc_fsm_e   fsm;
        logic [3:0] cnt;
        logic [7:0] opc;
        logic [7:0] acc;
        logic [7:0] idx;
        logic [7:0] mem;
        logic [7:0] res;
        fdc_flags_s flg;
        fdc_dec_s   dec;
        logic       taken;
        logic       wb;
        logic       pend;
        logic       take;
        logic       wait_q;
        logic [31:0] rdata;
    } fdc_state_s;

    fdc_state_s s_q;
    fdc_state_s s_d;

    function automatic fdc_dec_s fdc_decode(input logic [7:0] op);
        fdc_dec_s   d;
        logic [3:0] hi;
        logic [3:0] lo;
        int unsigned k;
        d  = '0;
        hi = op[7:4];
        lo = op[3:0];
        k  = 0;
        if (hi <= 4'h1) begin
            d = '{1'b1, CLS_BITMAN, MD_DIR, (hi == 4'h0) ? 2'h3 : 2'h2, BIT_CYC};
        end else if (hi == 4'h2) begin
            d = '{1'b1, CLS_BRANCH, MD_REL, 2'h2, BR_CYC};
        end else if (hi <= 4'h7) begin
            k = 32'(hi) - 3;
            if (op == OPC_UPROD) begin
                d = '{1'b1, CLS_RMW, MD_INH, 2'h1, UPROD_CYC};
            end else if (!(lo inside {4'h1, 4'h2, 4'h5, 4'hb, 4'he})) begin
                d = '{1'b1, CLS_RMW, MD_INH, RMW_LEN[k], RMW_CYC[k]};
                // probe on memory skips the write cycle
                if (lo == 4'hd && hi != 4'h4 && hi != 4'h5) begin
                    d.cyc = RMW_CYC[k] - 4'h1;
                end
                case (hi)
                    4'h3:    d.mode = MD_DIR;
                    4'h4:    d.mode = MD_INH_A;
                    4'h5:    d.mode = MD_INH_X;
                    4'h6:    d.mode = MD_IX8;
                    default: d.mode = MD_IX;
                endcase
            end
        end else if (hi <= 4'h9) begin
            d = '{1'b1, CLS_CONTROL, MD_INH, 2'h1, 4'h2};
            case (op)
                8'h80: d.cyc = 4'h9;
                8'h81: d.cyc = 4'h6;
                8'h83: d.cyc = 4'ha;
                8'h8e, 8'h8f, 8'h97, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d,
                8'h9f: d.cyc = 4'h2;
                default: d = '0;
            endcase
        end else if (op == OPC_BSR) begin
            d = '{1'b1, CLS_BRANCH, MD_REL, 2'h2, BSR_CYC};
        // no immediate store, no immediate goto
        end else if (!(hi == 4'ha && (lo == 4'h7 || lo == 4'hf || lo == 4'hc))) begin
            k = 32'(hi) - 10;
            d = '{1'b1, CLS_REGMEM, MD_IMM, RM_LEN[k], RM_CYC[k]};
            case (hi)
                4'ha:    d.mode = MD_IMM;
                4'hb:    d.mode = MD_DIR;
                4'hc:    d.mode = MD_EXT;
                4'hd:    d.mode = MD_IX16;
                4'he:    d.mode = MD_IX8;
                default: d.mode = MD_IX;
            endcase
            // goto one less, call two more cycles
            if (lo == 4'h7 || lo == 4'hf) begin
                d.cyc = RM_CYC[k] + 4'h1;
            end else if (lo == 4'hc) begin
                d.cyc = RM_CYC[k] - 4'h1;
            end else if (lo == 4'hd) begin
                d.cyc = RM_CYC[k] + 4'h2;
            end
        end
        return d;
    endfunction : fdc_decode

    function automatic fdc_exe_s fdc_execute(
        input fdc_dec_s   d,
        input logic [7:0] op,
        input logic [7:0] a,
        input logic [7:0] x,
        input logic [7:0] m,
        input fdc_flags_s f,
        input logic       pin
    );
        fdc_exe_s   e;
        logic [8:0] s;
        logic [7:0] v;
        logic [7:0] r;
        logic [15:0] p;
        logic       cond;
        e   = '{a, x, 8'h00, f, 1'b0, 1'b0};
        s   = '0;
        r   = '0;
        p   = '0;
        cond = 1'b0;
        v   = (d.mode == MD_INH_A) ? a : (d.mode == MD_INH_X) ? x : m;
        case (d.cls)
            CLS_REGMEM: begin
                // first operand acc or idx, second from memory
                v = (op[3:0] == 4'h3 || op[3:0] == 4'he || op[3:0] == 4'hf) ? x : a;
                case (op[3:0])
                    4'h9, 4'hb: begin
                        s = {1'b0, a} + {1'b0, m} + {8'h00, op[1] ? 1'b0 : f.c};
                        e.flg.h = a[4] ^ m[4] ^ s[4];
                        e.flg.c = s[8];
                        r = s[7:0];
                    end
                    4'h0, 4'h1, 4'h2, 4'h3: begin
                        s = {1'b0, v} - {1'b0, m} - {8'h00, (op[3:0] == 4'h2) & f.c};
                        e.flg.c = s[8];
                        r = s[7:0];
                    end
                    4'h4, 4'h5: r = a & m;
                    4'h8:       r = a ^ m;
                    4'ha:       r = a | m;
                    4'h6, 4'he: r = m;
                    default:    r = v;
                endcase
                // compares and bit test leave acc alone
                if (op[3:0] inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb}) begin
                    e.acc = r;
                end
                if (op[3:0] == 4'he) begin
                    e.idx = r;
                end
                e.wb = (op[3:0] == 4'h7 || op[3:0] == 4'hf);
                e.res = r;
                // goto and call touch no flags
                if (op[3:0] != 4'hc && op[3:0] != 4'hd) begin
                    e.flg.n = r[7];
                    e.flg.z = (r == 8'h00);
                end
            end
            CLS_RMW: begin
                if (op == OPC_UPROD) begin
                    // high byte to idx, low to acc
                    p = 16'(a) * 16'(x);
                    e.idx = p[15:8];
                    e.acc = p[7:0];
                    e.res = p[7:0];
                    e.flg.h = 1'b0;
                    e.flg.c = 1'b0;
                end else begin
                    case (op[3:0])
                        4'h0: begin r = 8'h00 - v; e.flg.c = (r != 8'h00); end
                        4'h3: begin r = ~v; e.flg.c = 1'b1; end
                        4'h4: begin r = {1'b0, v[7:1]}; e.flg.c = v[0]; end
                        4'h6: begin r = {f.c, v[7:1]}; e.flg.c = v[0]; end
                        4'h7: begin r = {v[7], v[7:1]}; e.flg.c = v[0]; end
                        4'h8: begin r = {v[6:0], 1'b0}; e.flg.c = v[7]; end
                        4'h9: begin r = {v[6:0], f.c}; e.flg.c = v[7]; end
                        4'ha: r = v - 8'h01;
                        4'hc: r = v + 8'h01;
                        4'hf: r = 8'h00;
                        default: r = v;
                    endcase
                    e.flg.n = r[7];
                    e.flg.z = (r == 8'h00);
                    e.res   = r;
                    // probe reads only, others write back in place
                    if (op[3:0] != 4'hd) begin
                        if (d.mode == MD_INH_A) begin
                            e.acc = r;
                        end else if (d.mode == MD_INH_X) begin
                            e.idx = r;
                        end else begin
                            e.wb = 1'b1;
                        end
                    end
                end
            end
            CLS_BRANCH: begin
                case (op[3:1])
                    3'h0:    cond = 1'b1;
                    3'h1:    cond = ~(f.c | f.z);
                    3'h2:    cond = ~f.c;
                    3'h3:    cond = ~f.z;
                    3'h4:    cond = ~f.h;
                    3'h5:    cond = ~f.n;
                    3'h6:    cond = ~f.i;
                    default: cond = ~pin;
                endcase
                e.taken = (op == OPC_BSR) | (cond ^ op[0]);
            end
            CLS_BITMAN: begin
                if (op[4] == 1'b0) begin
                    e.flg.c = m[op[3:1]];
                    e.taken = m[op[3:1]] ^ op[0];
                end else begin
                    // single write of the chosen bit
                    r = m;
                    r[op[3:1]] = ~op[0];
                    e.res = r;
                    e.wb  = 1'b1;
                end
            end
            CLS_CONTROL: begin
                case (op)
                    8'h97: e.idx = a;
                    8'h9f: e.acc = x;
                    8'h98: e.flg.c = 1'b0;
                    8'h99: e.flg.c = 1'b1;
                    8'h9a: e.flg.i = 1'b0;
                    8'h9b: e.flg.i = 1'b1;
                    default: e.res = 8'h00;
                endcase
            end
            default: e.res = 8'h00;
        endcase
        return e;
    endfunction : fdc_execute

    fdc_exe_s   exe;
    fdc_stat_s  stat;
    logic [7:0] wbyte;
    logic       wr_go;
    logic       rd_go;

    always_comb begin
        exe     = fdc_execute(s_q.dec, s_q.opc, s_q.acc, s_q.idx, s_q.mem, s_q.flg,
                              irq_pin_i);
        stat    = '{s_q.fsm == ST_EXEC, s_q.wb, s_q.taken, s_q.dec};
        wbyte   = avs_writedata_i[7:0];
        // write lands on the edge where waitrequest is seen low
        wr_go   = avs_write_i & ~s_q.wait_q & avs_byteenable_i[0];
        rd_go   = avs_read_i & s_q.wait_q;
        s_d     = s_q;
        s_d.wait_q = 1'b1;
        if ((avs_read_i | avs_write_i) & s_q.wait_q) begin
            s_d.wait_q = 1'b0;
        end
        if (rd_go) begin
            if (avs_address_i[4:2] == REG_OPCODE[4:2]) begin
                s_d.rdata = {24'h0, s_q.opc};
            end else if (avs_address_i[4:2] == REG_ACC[4:2]) begin
                s_d.rdata = {24'h0, s_q.acc};
            end else if (avs_address_i[4:2] == REG_IDX[4:2]) begin
                s_d.rdata = {24'h0, s_q.idx};
            end else if (avs_address_i[4:2] == REG_MEM[4:2]) begin
                s_d.rdata = {24'h0, s_q.mem};
            end else if (avs_address_i[4:2] == REG_FLAGS[4:2]) begin
                s_d.rdata = {27'h0, s_q.flg};
            end else if (avs_address_i[4:2] == REG_STAT[4:2]) begin
                s_d.rdata = 32'(stat);
            end else if (avs_address_i[4:2] == REG_RESULT[4:2]) begin
                s_d.rdata = {24'h0, s_q.res};
            end else begin
                s_d.rdata = {31'h0, s_q.pend};
            end
        end
        case (s_q.fsm)
            ST_IDLE: begin
                // software writes only land while idle, so no commit races them
                if (wr_go) begin
                    if (avs_address_i[4:2] == REG_OPCODE[4:2]) begin
                        s_d.opc = wbyte;
                        s_d.fsm = ST_EXEC;
                        s_d.dec = fdc_decode(wbyte);
                        s_d.cnt = (s_d.dec.cyc == 4'h0) ? 4'h0 : s_d.dec.cyc - 4'h1;
                    end else if (avs_address_i[4:2] == REG_ACC[4:2]) begin
                        s_d.acc = wbyte;
                    end else if (avs_address_i[4:2] == REG_IDX[4:2]) begin
                        s_d.idx = wbyte;
                    end else if (avs_address_i[4:2] == REG_MEM[4:2]) begin
                        s_d.mem = wbyte;
                    end else if (avs_address_i[4:2] == REG_FLAGS[4:2]) begin
                        s_d.flg = wbyte[4:0];
                    end
                end
            end
            default: begin
                // busy for the opcode's cycle count, then commit in one edge
                if (s_q.cnt != 4'h0) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else begin
                    s_d.fsm = ST_IDLE;
                    if (s_q.dec.valid) begin
                        s_d.flg   = exe.flg;
                        s_d.acc   = exe.acc;
                        s_d.idx   = exe.idx;
                        s_d.res   = exe.res;
                        s_d.wb    = exe.wb;
                        s_d.taken = exe.taken;
                        if (exe.wb) begin
                            s_d.mem = exe.res;
                        end
                    end else begin
                        s_d.wb    = 1'b0;
                        s_d.taken = 1'b0;
                    end
                end
            end
        endcase
        // request latched; taken only with mask clear; set wins
        s_d.take = s_q.pend & ~s_q.flg.i & ~s_q.take;
        s_d.pend = irq_req_i | (s_q.pend & ~s_d.take);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            s_q        <= '0;
            s_q.fsm    <= ST_IDLE;
            s_q.opc    <= RST_BYTE;
            s_q.flg    <= RST_FLAGS;
            s_q.wait_q <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata_o    = s_q.rdata;
    assign avs_waitrequest_o = s_q.wait_q;
    assign irq_take_o        = s_q.take;

endmodule : fdc_core

// ===== fdc_irq_model.sv
/* fdc_irq_model: interrupt source standing beside the core.
   assumes the bench asks for one-cycle requests on go_i. */
`timescale 1ns/1ps
module fdc_irq_model (
    input  wire logic clk_sys_i,
    input  wire logic go_i,
    input  wire logic lvl_i,
    output logic      irq_req_o = 1'b0,
    output logic      irq_pin_o = 1'b0
);
    // short request, the core must latch it
    always @(posedge clk_sys_i) begin
        irq_req_o <= go_i;
        irq_pin_o <= lvl_i;
    end
endmodule : fdc_irq_model

// ===== fdc_core_asserts.sv
/* fdc_core_asserts: port checks for the flag and decode core.
   assumes it is bound to every fdc_core instance. */
`timescale 1ns/1ps
module fdc_core_asserts
    import fdc_pkg::*;
#(
    parameter int ADDR_W = 5
) (
    input wire logic              clk_sys_i,
    input wire logic              rstn_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_writedata_i,
    input wire logic [3:0]        avs_byteenable_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic              irq_req_i,
    input wire logic              irq_pin_i,
    input wire logic              irq_take_o
);
    logic       req_seen_q;
    logic       open_seen_q;
    logic       rd_ok;
    logic       wr_ok;
    logic [2:0] wsel;
    assign rd_ok = avs_read_i && !avs_waitrequest_o;
    assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign wsel  = avs_address_i[4:2];
    // sticky, so busy-ignored writes only loosen the check
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            req_seen_q  <= 1'b0;
            open_seen_q <= 1'b0;
        end else begin
            req_seen_q  <= req_seen_q | irq_req_i;
            open_seen_q <= open_seen_q | (wr_ok && wsel == REG_FLAGS[4:2] && !avs_writedata_i[3])
                | (wr_ok && wsel == REG_OPCODE[4:2] && avs_writedata_i[7:0] == 8'h9a);
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest did not drop after a request");
    a_wait_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle: assert property (!(avs_read_i || avs_write_i) [*2] |-> avs_waitrequest_o)
        else $error("waitrequest low while idle");
    a_data_holds: assert property (!$stable(avs_readdata_o) |-> rd_ok || !$past(rstn_i))
        else $error("read data changed outside a read");
    a_flags_width: assert property (rd_ok && wsel == REG_FLAGS[4:2] |-> avs_readdata_o[31:5] == '0)
        else $error("flags word wider than five bits");
    a_byte_regs: assert property (rd_ok && wsel inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6}
        |-> avs_readdata_o[31:8] == '0)
        else $error("byte register shows upper bits");
    a_stat_top: assert property (rd_ok && wsel == REG_STAT[4:2] |-> avs_readdata_o[31:17] == '0)
        else $error("status shows bits above busy");
    a_pend_word: assert property (rd_ok && wsel == REG_IRQ[4:2] |-> avs_readdata_o[31:1] == '0)
        else $error("pending word shows upper bits");
    a_irq_masked: assert property (irq_take_o |-> open_seen_q && req_seen_q)
        else $error("interrupt taken while masked or without request");
endmodule : fdc_core_asserts

bind fdc_core fdc_core_asserts #(.ADDR_W(ADDR_W)) chk_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_req_i(irq_req_i), .irq_pin_i(irq_pin_i), .irq_take_o(irq_take_o));

// ===== fdc_core_tb_top.sv
/* fdc_core_tb_top: self-checking bench for the flag and decode core.
   assumes fdc_pkg, the checker bind and the interrupt model come first. */
`timescale 1ns/1ps
module fdc_core_tb_top;
    import fdc_pkg::*;
    typedef struct {logic [31:0] v; logic [31:0] m; string n;} fdc_exp_s;
    logic        clk_sys_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [4:0]  adr = '0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = '0;
    logic [3:0]  be = 4'h1;
    logic        go = 1'b0;
    logic        lvl = 1'b0;
    logic [31:0] rdata;
    logic        wreq;
    logic        irq_req;
    logic        irq_pin;
    logic        irq_take;
    int          fails = 0;
    int          checked = 0;
    int          cyc = 0;
    int          takes = 0;
    logic [31:0] st = 32'd71;
    logic [31:0] got;
    logic [7:0]  a, x, m, bm;
    logic        b;
    logic [15:0] p;
    logic [9:0]  e;
    fdc_exp_s    ent;
    fdc_exp_s    q[$];
    logic [3:0]  fam [6] = '{4'h9, 4'h8, 4'h3, 4'h1, 4'h2, 4'h5};
    logic [3:0]  mhi [6] = '{4'ha, 4'hb, 4'hc, 4'hf, 4'he, 4'hd};
    logic [3:0]  md [6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    logic [1:0]  ln [6] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
    logic [3:0]  cy [6] = '{4'h2, 4'h3, 4'h4, 4'h3, 4'h4, 4'h5};

    fdc_core dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .irq_req_i(irq_req), .irq_pin_i(irq_pin), .irq_take_o(irq_take));
    fdc_irq_model irq_u (.clk_sys_i(clk_sys_i), .go_i(go), .lvl_i(lvl), .irq_req_o(irq_req),
        .irq_pin_o(irq_pin));

    always #4 clk_sys_i = ~clk_sys_i;

    function automatic logic [7:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st[7:0];
    endfunction : xs

    // reference alu: {half carry, carry or borrow, result}
    function automatic logic [9:0] alu(input logic [3:0] f, input logic [7:0] a, x, m, input logic c);
        logic [8:0] s;
        case (f)
            4'h9: s = {1'b0, a} + m + c;
            4'h8: s = {c, a ^ m};
            4'h3: s = {1'b0, x} - m;
            4'h1: s = {1'b0, a} - m;
            4'h2: s = {1'b0, a} - m - c;
            default: s = {c, a & m};
        endcase
        return {(a[3:0] + m[3:0] + c) > 5'hf, s};
    endfunction : alu

    task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] seen);
        checked++;
        if (seen !== ex) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, ex, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // request held until waitrequest is sampled low
    task automatic bus(input logic [4:0] ad, input logic w, input logic [31:0] d);
        @(posedge clk_sys_i);
        adr <= ad;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk_sys_i);
        end while (wreq !== 1'b0);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic exr(input logic [4:0] ad, input logic [31:0] v, input logic [31:0] mk, input string n);
        q.push_back('{v, mk, n});
        bus(ad, 1'b0, '0);
    endtask : exr

    // issue an opcode, then poll busy; poll reads carry no expectation
    task automatic run(input logic [7:0] op);
        int k;
        k = 0;
        bus(REG_OPCODE, 1'b1, {24'h0, op});
        do begin
            exr(REG_STAT, '0, '0, "poll");
            k++;
        end while (got[16] !== 1'b0 && k < 30);
        if (k >= 30) fails++;
    endtask : run

    always @(posedge clk_sys_i) begin
        cyc++;
        if (irq_take === 1'b1) takes++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    always @(posedge clk_sys_i) begin
        if (rd && wreq === 1'b0 && q.size() > 0) begin
            ent = q.pop_front();
            if (ent.m != '0) chk(ent.n, ent.v & ent.m, rdata & ent.m);
        end
    end

    initial begin
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        exr(REG_FLAGS, 32'h8, '1, "flags after reset");
        for (int f = 0; f < 6; f++) begin
            for (int k = 0; k < 6; k++) begin
                a = xs();
                x = xs();
                m = xs();
                b = xs() > 8'h7f;
                bus(REG_ACC, 1'b1, {24'h0, a});
                bus(REG_IDX, 1'b1, {24'h0, x});
                bus(REG_MEM, 1'b1, {24'h0, m});
                bus(REG_FLAGS, 1'b1, {27'h0, 4'h4, b});
                run({mhi[k], fam[f]});
                e = alu(fam[f], a, x, m, b);
                exr(REG_ACC, (fam[f] inside {4'h9, 4'h8, 4'h2}) ? e[7:0] : a, '1, "acc");
                exr(REG_FLAGS, {27'h0, e[9], 1'b1, e[7], e[7:0] == 8'h0, e[8]},
                    {27'h0, fam[f] == 4'h9, 4'hf}, "flags");
                exr(REG_STAT, {18'h0, 4'h9, md[k], ln[k], cy[k]}, 32'h3fff, "decode");
            end
        end
        $display("test register-memory done");
        a = xs();
        x = xs();
        m = xs();
        bus(REG_ACC, 1'b1, {24'h0, a});
        bus(REG_IDX, 1'b1, {24'h0, x});
        bus(REG_FLAGS, 1'b1, {27'h0, 2'b11, m[1:0], 1'b1});
        run(8'h42);
        p = a * x;
        exr(REG_ACC, p[7:0], '1, "product low");
        exr(REG_IDX, p[15:8], '1, "product high");
        exr(REG_FLAGS, {27'h0, 2'b01, m[1:0], 1'b0}, '1, "product flags");
        exr(REG_STAT, 32'h1b, 32'h3f, "product decode");
        run(8'ha7);
        exr(REG_STAT, '0, 32'h2000, "no immediate store");
        run(8'hb7);
        exr(REG_MEM, p[7:0], '1, "stored acc");
        run(8'hbc);
        exr(REG_ACC, p[7:0], '1, "acc after goto");
        exr(REG_FLAGS, {27'h0, 2'b01, p[7], p[7:0] == 8'h0, 1'b0}, '1, "flags after goto");
        $display("test product and store done");
        for (int o = 32; o < 48; o++) begin
            b = xs() > 8'h7f;
            lvl <= b;
            run(8'(o));
            exr(REG_STAT, {17'h0, o == 32 || (o == 46 && !b) || (o == 47 && b), 14'h2e63},
                (o < 34 || o > 45) ? 32'h7fff : 32'h3fff, "branch");
        end
        $display("test branch done");
        for (int n = 0; n < 8; n++) begin
            m = xs();
            b = xs() > 8'h7f;
            bm = 8'h1 << n;
            bus(REG_MEM, 1'b1, {24'h0, m});
            run({4'h0, 3'(n), b});
            exr(REG_FLAGS, {31'h0, m[n]}, 32'h1, "tested bit");
            exr(REG_STAT, {17'h0, m[n] == !b, 14'h0}, 32'h4000, "bit branch");
            run({4'h1, 3'(n), b});
            exr(REG_MEM, b ? (m & ~bm) : (m | bm), '1, "bit set clear");
        end
        $display("test bit done");
        m = xs();
        bus(REG_MEM, 1'b1, {24'h0, m});
        run(8'h3d);
        exr(REG_MEM, m, '1, "probe memory");
        exr(REG_FLAGS, {29'h0, m[7], m == 8'h0, 1'b0}, 32'h6, "probe flags");
        exr(REG_STAT, '0, 32'h8000, "probe write-back");
        run(8'h38);
        exr(REG_MEM, {m[6:0], 1'b0}, '1, "shift memory");
        exr(REG_FLAGS, {31'h0, m[7]}, 32'h1, "shift carry");
        $display("test read-modify-write done");
        go <= 1'b1;
        @(posedge clk_sys_i);
        go <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        exr(REG_IRQ, 32'h1, '1, "pending while masked");
        chk("take while masked", '0, 32'(takes));
        bus(REG_FLAGS, 1'b1, '0);
        repeat (6) @(posedge clk_sys_i);
        chk("take after unmask", 32'h1, 32'(takes));
        exr(REG_IRQ, '0, '1, "pending cleared");
        $display("test interrupt done");
        report_and_stop();
    end
endmodule : fdc_core_tb_top
